// ### hdl/led_ctrl_pkg.sv
`default_nettype none
package led_ctrl_pkg;
  // Clock rate and conversion helpers.
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned CLK_NS            = 40;
  // Timing figures in microseconds as printed.
  localparam int unsigned DETECT_DELAY_US   = 100;
  localparam int unsigned DETECT_LOW_US     = 260;
  localparam int unsigned DETECT_WINDOW_US  = 1000;
  localparam int unsigned EN_OFF_US         = 2500;
  localparam int unsigned PWM_OFF_US        = 20000;
  localparam int unsigned STARTUP_LIMIT_US  = 5000;
  localparam int unsigned PHASE_MAX_US      = 360;
  localparam int unsigned ACK_MAX_US        = 512;
  // Cycle counts: least times round up, longest times round down.
  localparam int unsigned DETECT_DELAY_CYC  = DETECT_DELAY_US * 1000 / CLK_NS;
  localparam int unsigned DETECT_LOW_CYC    =
    (DETECT_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DETECT_WINDOW_CYC = DETECT_WINDOW_US * 1000 / CLK_NS;
  localparam int unsigned EN_OFF_CYC        =
    (EN_OFF_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWM_OFF_CYC       =
    (PWM_OFF_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STARTUP_LIMIT_CYC =
    (STARTUP_LIMIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PHASE_MAX_CYC     = PHASE_MAX_US * 1000 / CLK_NS;
  localparam int unsigned ACK_MAX_CYC       = ACK_MAX_US * 1000 / CLK_NS;
  // Command frame layout.
  localparam int unsigned FRAME_BITS        = 24;
  localparam int unsigned CODE_BITS         = 9;
  localparam logic [7:0]  DEVICE_ADDR       = 8'h8f;
  localparam int unsigned ACK_REQ_POS       = 9;
  localparam logic [8:0]  CODE_DEFAULT      = 9'h1ff;
  localparam logic [8:0]  CODE_FULL         = 9'h1ff;
  localparam int unsigned CNT_W             = 20;
endpackage : led_ctrl_pkg
`default_nettype wire

// ### hdl/led_link_if.sv
`default_nettype none
interface led_link_if;
  logic en_host;     // Enable pin level driven by the host.
  logic en_dev_low;  // Device pulls enable low for acknowledge.
  logic pwm_pin;     // PWM pin level driven by the host.
  logic en_line;     // Resolved enable wire (open-drain acknowledge).
  assign en_line = en_host & ~en_dev_low;
  modport device (input en_line, input pwm_pin, output en_dev_low);
  modport host (input en_line, output en_host, output pwm_pin);
endinterface : led_link_if
`default_nettype wire

// ### hdl/led_driver_ctrl.sv
// Functional notes
// - Start needs supply, enable high, PWM active.
// - Detection window; fallback to PWM dimming.
// - After window sample sinks, drop grounded.
// - Both sinks grounded: stay in shutdown.
// - Enable low 2.5ms or PWM 20ms: shutdown.
// - Reduced current limit first 5ms switching.
// - Undervoltage shuts down, auto restart.
// - Check overvoltage comparators every switching cycle.
// - Switch overvoltage latches off until toggle.
// - Switch overvoltage turns switch off.
// - Overcurrent holds switch off until next cycle.
// - Overtemperature shuts down, auto resume.
// - Host: PWM high, raise enable.
// - Enable low over 260us within window.
// - Pattern needed on every start-up.
// - 9-bit code, default all ones.
// - Code restored to default at shutdown.
// - Host holds the unused pin high.
// - PWM mode scales by measured duty.
// - 24-bit LSB-first frame, address 0x8f.
// - Bit value by high/low ratio, 360us cap.
// - Acknowledge low at most 512us.
`default_nettype none
module led_driver_ctrl
  import led_ctrl_pkg::*;
#(
  parameter int unsigned EN_OFF_CNT  = led_ctrl_pkg::EN_OFF_CYC,
  parameter int unsigned PWM_OFF_CNT = led_ctrl_pkg::PWM_OFF_CYC,
  parameter int unsigned LIMIT_CNT   = led_ctrl_pkg::STARTUP_LIMIT_CYC,
  parameter int unsigned ACK_CNT     = led_ctrl_pkg::ACK_MAX_CYC
) (
  input  wire logic                 sys_clk,         // System clock.
  input  wire logic                 reset,           // Async reset.
  led_link_if.device                link,            // Enable and PWM pins.
  input  wire logic                 supply_ok,       // Supply above lockout.
  input  wire logic [1:0]           led_sink_pin,    // High: sink grounded.
  input  wire logic                 switch_ovp,      // Switch node overvolt.
  input  wire logic [1:0]           sink_ovp,        // Sink overvoltage.
  input  wire logic                 over_current,    // Inductor over limit.
  input  wire logic                 over_temp,       // Junction too hot.
  input  wire logic                 cycle_start,     // Switching cycle tick.
  output logic                      running,         // Boost switching on.
  output logic                      switch_on,       // Boost switch gate.
  output logic                      startup_limit,   // Reduced limit select.
  output logic                      onewire_mode,    // One-wire dimming on.
  output logic [1:0]                channel_en,      // Active channels.
  output logic [CODE_BITS-1:0]      brightness_code, // Current code.
  output logic [CNT_W-1:0]          duty_high,       // PWM high count.
  output logic [CNT_W-1:0]          duty_period      // PWM period count.
);
  import led_ctrl_pkg::*;
  typedef enum {ST_OFF, ST_DETECT, ST_RUN, ST_LATCH} state_t;
  state_t state;
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read.
  logic [1:0] en_sync, pwm_sync, sup_sync, temp_sync;
  logic en_prev, pwm_prev;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_sync   <= 2'h0;
      pwm_sync  <= 2'h0;
      sup_sync  <= 2'h0;
      temp_sync <= 2'h0;
      en_prev   <= 1'b0;
      pwm_prev  <= 1'b0;
    end else begin
      en_sync   <= {en_sync[0], link.en_line};
      pwm_sync  <= {pwm_sync[0], link.pwm_pin};
      sup_sync  <= {sup_sync[0], supply_ok};
      temp_sync <= {temp_sync[0], over_temp};
      en_prev   <= en_sync[1];
      pwm_prev  <= pwm_sync[1];
    end
  end
  wire en_s     = en_sync[1];
  wire pwm_s    = pwm_sync[1];
  wire en_rise  = en_s & ~en_prev;
  wire en_fall  = ~en_s & en_prev;
  wire pwm_rise = pwm_s & ~pwm_prev;
  //////////////////////////////////////////////////////////////////////////
  // Low-time counters for the shutdown timeouts.
  logic [CNT_W-1:0] en_low_cnt, pwm_low_cnt, pwm_hi_run, pwm_per_run;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_low_cnt  <= '0;
      pwm_low_cnt <= '0;
    end else begin
      en_low_cnt  <= en_s ? '0 :
                     en_low_cnt + ((en_low_cnt == '1) ? 1'b0 : 1'b1);
      pwm_low_cnt <= pwm_s ? '0 :
                     pwm_low_cnt + ((pwm_low_cnt == '1) ? 1'b0 : 1'b1);
    end
  end
  wire en_timeout  = en_low_cnt >= CNT_W'(EN_OFF_CNT);
  wire pwm_timeout = pwm_low_cnt >= CNT_W'(PWM_OFF_CNT);
  // Conditions that force or hold shutdown.
  wire fault_off   = ~sup_sync[1] | temp_sync[1];
  wire start_ok    = sup_sync[1] & en_s & pwm_s;
  wire ovp_hit     = switch_ovp | (|(sink_ovp & channel_en));
  //////////////////////////////////////////////////////////////////////////
  // Start-up sequencing and mode detection.
  logic [CNT_W-1:0] win_cnt, low_cnt, run_cnt;
  logic             pattern_seen;
  wire win_done  = win_cnt >= CNT_W'(DETECT_WINDOW_CYC);
  wire low_ok    = low_cnt >= CNT_W'(DETECT_LOW_CYC);
  wire in_delay  = win_cnt < CNT_W'(DETECT_DELAY_CYC);
  wire both_gnd  = &led_sink_pin;
  wire shut_now  = fault_off | en_timeout | pwm_timeout;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state        <= ST_OFF;
      win_cnt      <= '0;
      low_cnt      <= '0;
      pattern_seen <= 1'b0;
      onewire_mode <= 1'b0;
      channel_en   <= 2'h0;
      running      <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          running      <= 1'b0;
          channel_en   <= 2'h0;
          onewire_mode <= 1'b0;
          win_cnt      <= '0;
          low_cnt      <= '0;
          pattern_seen <= 1'b0;
          if (start_ok && !fault_off && !en_timeout) state <= ST_DETECT;
        end
        ST_DETECT: begin
          win_cnt <= win_cnt + 1'b1;
          if (!en_s && !in_delay) low_cnt <= low_cnt + 1'b1;
          else low_cnt <= '0;
          if (en_rise && low_ok) pattern_seen <= 1'b1;
          if (fault_off || pwm_timeout) begin
            state <= ST_OFF;
          end else if (win_done && en_s) begin
            onewire_mode <= pattern_seen;
            if (both_gnd) begin
              state <= ST_OFF;
            end else begin
              channel_en <= ~led_sink_pin;
              running    <= 1'b1;
              state      <= ST_RUN;
            end
          end else if (win_done && en_timeout) begin
            state <= ST_OFF;
          end
        end
        ST_RUN: begin
          if (ovp_hit && switch_ovp) begin
            running <= 1'b0;
            state   <= ST_LATCH;
          end else if (shut_now || ovp_hit) begin
            running <= 1'b0;
            state   <= ST_OFF;
          end
        end
        ST_LATCH: begin
          running <= 1'b0;
          if (en_fall || en_rise || pwm_rise || fault_off)
            state <= ST_OFF;
        end
        default: state <= ST_OFF;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Reduced start-up limit and pulse-by-pulse switch control.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run_cnt       <= '0;
      startup_limit <= 1'b1;
      switch_on     <= 1'b0;
    end else begin
      if (!running) run_cnt <= '0;
      else if (run_cnt != '1) run_cnt <= run_cnt + 1'b1;
      startup_limit <= run_cnt < CNT_W'(LIMIT_CNT);
      if (!running || ovp_hit || over_current) switch_on <= 1'b0;
      else if (cycle_start) switch_on <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // PWM duty measurement: high count and period of the last cycle.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwm_hi_run  <= '0;
      pwm_per_run <= '0;
      duty_high   <= '0;
      duty_period <= '0;
    end else if (pwm_rise) begin
      duty_high   <= pwm_hi_run;
      duty_period <= pwm_per_run;
      pwm_hi_run  <= 20'h1;
      pwm_per_run <= 20'h1;
    end else if (pwm_s && pwm_per_run >= CNT_W'(PWM_OFF_CNT)) begin
      duty_high   <= 20'h1;
      duty_period <= 20'h1;
    end else begin
      if (pwm_s) pwm_hi_run <= pwm_hi_run + 1'b1;
      if (pwm_per_run != '1) pwm_per_run <= pwm_per_run + 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // One-wire receiver: bit value from high versus low phase length.
  logic [CNT_W-1:0]            hi_len, lo_len;
  logic [FRAME_BITS-1:0]       shreg;
  logic [4:0]                  nbits;
  logic                        ack_pend;
  logic [CNT_W-1:0]            ack_cnt;
  logic                        ack_drive;
  wire rx_on     = state == ST_RUN && onewire_mode && !ack_drive;
  // A lead bit's high phase merges with the idle level, so that bit is
  // judged by its low phase alone; a lead one must keep its low short.
  localparam logic [CNT_W-1:0] LEAD_SPLIT = 20'h000fa;
  wire lead_bit  = hi_len > CNT_W'(PHASE_MAX_CYC);
  wire bit_val   = lead_bit ? (lo_len < LEAD_SPLIT)
                            : (hi_len > lo_len);
  wire eos       = en_s && hi_len > CNT_W'(PHASE_MAX_CYC);
  wire frame_ok  = nbits == 5'(FRAME_BITS) &&
                   shreg[FRAME_BITS-1 -: 8] == DEVICE_ADDR;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hi_len          <= '0;
      lo_len          <= '0;
      shreg           <= '0;
      nbits           <= 5'h0;
      brightness_code <= CODE_DEFAULT;
      ack_pend        <= 1'b0;
    end else if (state != ST_RUN) begin
      brightness_code <= CODE_DEFAULT;
      nbits           <= 5'h0;
      hi_len          <= '0;
      lo_len          <= '0;
      ack_pend        <= 1'b0;
    end else if (rx_on) begin
      ack_pend <= 1'b0;
      if (en_rise && lo_len != '0) begin
        // A bit ends when its low phase ends, so high and low pair up.
        shreg  <= {bit_val, shreg[FRAME_BITS-1:1]};
        if (nbits != 5'(FRAME_BITS)) nbits <= nbits + 1'b1;
        hi_len <= '0;
        lo_len <= '0;
      end else if (eos) begin
        if (frame_ok) begin
          brightness_code <= shreg[CODE_BITS-1:0];
          ack_pend        <= shreg[ACK_REQ_POS];
        end
        nbits  <= 5'h0;
        // Parked just above the limit, so a long idle never wraps.
        hi_len <= CNT_W'(PHASE_MAX_CYC + 1);
        lo_len <= '0;
      end else if (en_s) begin
        hi_len <= hi_len + 1'b1;
      end else begin
        lo_len <= lo_len + 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Acknowledge pulse; the counter caps the low drive time.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_cnt   <= '0;
      ack_drive <= 1'b0;
    end else if (ack_pend) begin
      ack_drive <= 1'b1;
      ack_cnt   <= '0;
    end else if (ack_drive) begin
      ack_cnt <= ack_cnt + 1'b1;
      if (ack_cnt + 1'b1 >= CNT_W'(ACK_CNT)) ack_drive <= 1'b0;
    end
  end
  assign link.en_dev_low = ack_drive;
endmodule : led_driver_ctrl
`default_nettype wire

// ### hdl/led_host_ctrl.sv
`default_nettype none
module led_host_ctrl
  import led_ctrl_pkg::*;
(
  input  wire logic                 sys_clk,     // System clock.
  input  wire logic                 reset,       // Async reset.
  led_link_if.host                  link,        // Enable and PWM pins.
  input  wire logic                 start,       // Pulse: begin start-up.
  input  wire logic                 use_onewire, // Select one-wire mode.
  input  wire logic                 send,        // Pulse: send a command.
  input  wire logic [CODE_BITS-1:0] code,        // Brightness to send.
  input  wire logic                 ack_req,     // Request acknowledge.
  input  wire logic                 stop,        // Pulse: shut device down.
  output logic                      busy         // Sequence in progress.
);
  import led_ctrl_pkg::*;
  typedef enum {H_IDLE, H_WAIT, H_LOW, H_ON, H_BIT, H_EOS} hstate_t;
  hstate_t          hs;
  logic [CNT_W-1:0] cnt;
  logic [FRAME_BITS-1:0] frame;
  logic [4:0]       left;
  logic             en_q, pwm_q, phase;
  // Bit phases: short = 5us, long = 15us (ratio three); a lead one bit
  // keeps its low under the receiver's split.
  localparam logic [CNT_W-1:0] SHORT_CYC = 20'h0007d;
  localparam logic [CNT_W-1:0] LONG_CYC  = 20'h00177;
  localparam logic [CNT_W-1:0] EOS_CYC   = CNT_W'(PHASE_MAX_CYC + 100);
  wire [CNT_W-1:0] hi_t = frame[0] ? LONG_CYC : SHORT_CYC;
  wire [CNT_W-1:0] lo_t = frame[0] ? SHORT_CYC : LONG_CYC;
  //////////////////////////////////////////////////////////////////////////
  // Start sequence, detection pattern and LSB-first frame sending.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hs <= H_IDLE; cnt <= '0; frame <= '0; left <= 5'h0;
      en_q <= 1'b0; pwm_q <= 1'b0; phase <= 1'b0; busy <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      case (hs)
        H_IDLE: begin
          busy <= 1'b0;
          if (stop) begin en_q <= 1'b0; pwm_q <= 1'b0; end
          else if (start) begin
            pwm_q <= 1'b1; en_q <= 1'b1; cnt <= '0; busy <= 1'b1;
            hs <= use_onewire ? H_WAIT : H_ON;
          end else if (send && en_q) begin
            frame <= {DEVICE_ADDR, 6'h0, ack_req, code};
            left <= 5'(FRAME_BITS); phase <= 1'b1; cnt <= '0;
            busy <= 1'b1; hs <= H_BIT;
          end
        end
        H_WAIT: if (cnt >= CNT_W'(DETECT_DELAY_CYC + 25)) begin
          en_q <= 1'b0; cnt <= '0; hs <= H_LOW;
        end
        H_LOW: if (cnt >= CNT_W'(DETECT_LOW_CYC + 2500)) begin
          // Count on from the start, so the wait ends 250 cycles after the window.
          en_q <= 1'b1; hs <= H_ON;
          cnt <= CNT_W'(DETECT_DELAY_CYC + DETECT_LOW_CYC + 2527);
        end
        H_ON: if (cnt >= CNT_W'(DETECT_WINDOW_CYC + 250)) hs <= H_IDLE;
        H_BIT: begin
          en_q <= phase;
          if (phase && cnt >= hi_t) begin phase <= 1'b0; cnt <= '0; end
          else if (!phase && cnt >= lo_t) begin
            phase <= 1'b1; cnt <= '0; frame <= frame >> 1;
            left <= left - 5'h1;
            if (left == 5'h1) hs <= H_EOS;
          end
        end
        H_EOS: begin
          en_q <= 1'b1;
          if (cnt >= EOS_CYC + CNT_W'(ACK_MAX_CYC)) hs <= H_IDLE;
        end
        default: hs <= H_IDLE;
      endcase
    end
  end
  assign link.en_host = en_q;
  assign link.pwm_pin = pwm_q;
endmodule : led_host_ctrl
`default_nettype wire

// ### verification/led_link_asserts.sv
`default_nettype none
module led_link_asserts
  import led_ctrl_pkg::*;
#(
  parameter int unsigned EN_OFF_CNT = 8000,
  parameter int unsigned LIMIT_CNT  = 300,
  parameter int unsigned ACK_CNT    = 200
) (
  input wire logic                 sys_clk,         // System clock.
  input wire logic                 reset,           // Async reset.
  input wire logic                 en_line,         // Resolved enable wire.
  input wire logic                 en_dev_low,      // Acknowledge pull-low.
  input wire logic                 pwm_pin,         // PWM pin level.
  input wire logic                 supply_ok,       // Supply above lockout.
  input wire logic [1:0]           led_sink_pin,    // Grounded sinks.
  input wire logic                 switch_ovp,      // Switch overvoltage.
  input wire logic                 over_current,    // Inductor over limit.
  input wire logic                 cycle_start,     // Switching cycle tick.
  input wire logic                 running,         // Boost switching on.
  input wire logic                 switch_on,       // Boost switch gate.
  input wire logic                 startup_limit,   // Reduced limit select.
  input wire logic [1:0]           channel_en,      // Active channels.
  input wire logic [CODE_BITS-1:0] brightness_code  // Current code.
);
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths saturate, so a long idle stretch cannot wrap into range.
  logic [19:0] en_lo_cnt;
  logic [19:0] ack_cnt;
  logic [19:0] run_cnt;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_lo_cnt <= '0;
      ack_cnt   <= '0;
      run_cnt   <= '0;
    end else begin
      en_lo_cnt <= en_line ? '0 : en_lo_cnt + {19'h0, ~&en_lo_cnt};
      ack_cnt   <= en_dev_low ? ack_cnt + {19'h0, ~&ack_cnt} : '0;
      run_cnt   <= running ? run_cnt + {19'h0, ~&run_cnt} : '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // All checks share the one clock and its reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  property p_start_pins;
    $rose(running) |-> pwm_pin && en_line && supply_ok;
  endproperty
  a_start_pins: assert property (p_start_pins)
    else $error("running rose without supply, enable and pwm");
  property p_chan_sample;
    $rose(running) |-> channel_en == ~led_sink_pin;
  endproperty
  a_chan_sample: assert property (p_chan_sample)
    else $error("grounded sink left enabled");
  property p_not_both;
    running |-> channel_en != 2'b00;
  endproperty
  a_not_both: assert property (p_not_both)
    else $error("running with no channel");
  property p_en_off;
    en_lo_cnt == EN_OFF_CNT + 8 |-> !running;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("enable low too long but still running");
  property p_limit_start;
    $rose(running) |-> startup_limit [*8];
  endproperty
  a_limit_start: assert property (p_limit_start)
    else $error("reduced limit missing at start");
  property p_limit_end;
    run_cnt == LIMIT_CNT + 4 |-> !startup_limit;
  endproperty
  a_limit_end: assert property (p_limit_end)
    else $error("reduced limit kept too long");
  property p_undervolt;
    !supply_ok |-> ##[1:6] !running;
  endproperty
  a_undervolt: assert property (p_undervolt)
    else $error("running under lockout");
  property p_sw_ovp;
    switch_ovp |-> ##[1:6] (!running && !switch_on);
  endproperty
  a_sw_ovp: assert property (p_sw_ovp)
    else $error("switch overvoltage did not shut down");
  property p_over_cur;
    over_current && !cycle_start |=> !switch_on;
  endproperty
  a_over_cur: assert property (p_over_cur)
    else $error("switch on after overcurrent");
  property p_ack_len;
    ack_cnt <= ACK_CNT;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge held too long");
  property p_code_off;
    !running ##1 !running |-> brightness_code == CODE_DEFAULT;
  endproperty
  a_code_off: assert property (p_code_off)
    else $error("code not at default while off");
  c_run: cover property ($rose(running));
  c_ack: cover property ($rose(en_dev_low));
  c_ovp: cover property (switch_ovp && running);
endmodule : led_link_asserts
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_ctrl_pkg::*;
  localparam int EN_OFF = 8000;
  localparam int LIM    = 300;
  localparam int ACK    = 200;
  localparam int BOUND  = 70000;
  logic        sys_clk = 1'b0, reset = 1'b1, supply_ok = 1'b1;
  logic [1:0]  led_sink_pin = 2'b00, sink_ovp = 2'b00;
  logic        switch_ovp = 1'b0, over_current = 1'b0, over_temp = 1'b0;
  logic        cycle_start = 1'b0, start = 1'b0, use_onewire = 1'b0;
  logic        send = 1'b0, ack_req = 1'b0, stop = 1'b0;
  logic [8:0]  code = 9'h000, code_v;
  logic        running, switch_on, startup_limit, onewire_mode, busy;
  logic [1:0]  channel_en;
  logic [8:0]  brightness_code;
  logic [19:0] duty_high, duty_period;
  logic [4:0]  tick_div = 5'h00;
  logic [23:0] got = 24'h0;
  logic        frame_on = 1'b0, bad_phase = 1'b0, ack_seen = 1'b0, bit_v;
  int          hi_n = 0, lo_n = 0, n_tests = 0, n_mismatch = 0;
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  led_link_if led_link_if_i ();
  led_driver_ctrl #(.EN_OFF_CNT(EN_OFF), .PWM_OFF_CNT(10000),
    .LIMIT_CNT(LIM), .ACK_CNT(ACK)) led_driver_ctrl_i (
    .sys_clk, .reset, .link(led_link_if_i), .supply_ok, .led_sink_pin,
    .switch_ovp, .sink_ovp, .over_current, .over_temp, .cycle_start,
    .running, .switch_on, .startup_limit, .onewire_mode, .channel_en,
    .brightness_code, .duty_high, .duty_period);
  led_host_ctrl led_host_ctrl_i (.sys_clk, .reset, .link(led_link_if_i),
    .start, .use_onewire, .send, .code, .ack_req, .stop, .busy);
  led_link_asserts #(.EN_OFF_CNT(EN_OFF), .LIMIT_CNT(LIM), .ACK_CNT(ACK))
    led_link_asserts_i (.sys_clk, .reset,
    .en_line(led_link_if_i.en_line), .en_dev_low(led_link_if_i.en_dev_low),
    .pwm_pin(led_link_if_i.pwm_pin), .supply_ok, .led_sink_pin,
    .switch_ovp, .over_current, .cycle_start, .running, .switch_on,
    .startup_limit, .channel_en, .brightness_code);
  ////////////////////////////////////////////////////////////////////////////
  // Switching ticks every 32 clocks, with an overcurrent hit nine clocks after each cycle start.
  always @(posedge sys_clk) begin
    tick_div <= tick_div + 5'h01;
    cycle_start <= (tick_div == 5'h00);
    over_current <= (tick_div == 5'h09);
  end
  // Frame decoder on the host drive; the first bit's high phase merges
  // with the idle level, so that bit is judged by its low phase alone.
  always @(posedge sys_clk) begin
    if (frame_on) begin
      if (led_link_if_i.en_host && lo_n > 0) begin
        bit_v = (hi_n > PHASE_MAX_CYC) ? (lo_n < 250) : (hi_n > lo_n);
        if (hi_n <= PHASE_MAX_CYC && (bit_v ? hi_n < 2 * lo_n
                                            : lo_n < 2 * hi_n)) begin
          bad_phase = 1'b1;
        end
        if (lo_n > PHASE_MAX_CYC) begin
          bad_phase = 1'b1;
        end
        got = {bit_v, got[23:1]};
        hi_n = 0;
        lo_n = 0;
      end
      if (led_link_if_i.en_host) begin
        hi_n++;
      end else begin
        lo_n++;
      end
      ack_seen = ack_seen | led_link_if_i.en_dev_low;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] exp_frame(input logic [8:0] c,
                                            input logic a);
    exp_frame = {DEVICE_ADDR, 6'h00, a, c};
  endfunction : exp_frame
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait on running or busy; running out counts as a mismatch.
  task automatic wait_for(input logic lvl, input logic on_busy);
    int n;
    n = 0;
    while (((on_busy ? busy : running) !== lvl) && n < BOUND) begin
      step(1);
      n++;
    end
    if (n >= BOUND) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_for
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(52273));
    step(8);
    reset = 1'b0;
    step(2);
    chk(24'(running), 24'h0);
    chk(24'(brightness_code), 24'(CODE_DEFAULT));
    $display("reset test done");
    led_sink_pin = ($urandom % 2) ? 2'b01 : 2'b10;
    use_onewire = 1'b1;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_for(1'b1, 1'b0);
    chk(24'(onewire_mode), 24'h1);
    chk(24'(channel_en), {22'h0, ~led_sink_pin});
    chk(24'(brightness_code), 24'(CODE_DEFAULT));
    step(LIM + 10);
    chk(24'(startup_limit), 24'h0);
    wait_for(1'b0, 1'b1);
    code_v = 9'($urandom % 511);
    code = code_v;
    ack_req = 1'b1;
    frame_on = 1'b1;
    send = 1'b1;
    step(1);
    send = 1'b0;
    wait_for(1'b1, 1'b1);
    wait_for(1'b0, 1'b1);
    frame_on = 1'b0;
    chk(got, exp_frame(code_v, 1'b1));
    chk(24'(bad_phase), 24'h0);
    chk(24'(ack_seen), 24'h1);
    chk(24'(brightness_code), 24'(code_v));
    stop = 1'b1;
    step(1);
    stop = 1'b0;
    wait_for(1'b0, 1'b0);
    step(2);
    chk(24'(brightness_code), 24'(CODE_DEFAULT));
    $display("one-wire test done");
    led_sink_pin = 2'b00;
    use_onewire = 1'b0;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_for(1'b1, 1'b0);
    chk(24'(onewire_mode), 24'h0);
    chk(24'(channel_en), 24'h3);
    step(10);
    chk(24'(duty_high), 24'h1);
    chk(24'(duty_period), 24'h1);
    switch_ovp = 1'b1;
    step(1);
    switch_ovp = 1'b0;
    step(8);
    chk(24'(running), 24'h0);
    chk(24'(switch_on), 24'h0);
    step(50);
    chk(24'(running), 24'h0);
    $display("pwm test done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
